/* periph_chain.sv */
// Peripheral chain model: a silent station ahead of a replying one
`default_nettype none
module periph_chain (
    input  wire logic        sys_clk,    // Clock
    input  wire logic        rst_n,      // Reset, active low
    input  wire logic        grant,      // Grant from the unit
    input  wire logic [2:0]  grant_chan, // Granted channel
    input  wire logic [2:0]  silent_ch,  // Channel of the silent station, 0 none
    input  wire logic [2:0]  reply_ch,   // Channel of the replying station, 0 none
    input  wire logic [35:0] word,       // Function word to return
    input  wire logic [3:0]  delay,      // Cycles before the reply
    output logic [6:0]       req_lvl,    // Request levels
    output logic             fw_valid,   // Reply strobe
    output logic [35:0]      fw_data     // Reply word
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       grant_q;
    logic       armed;
    logic [3:0] cnt;

    function automatic logic [6:0] chan_bit(input logic [2:0] ch);
        return (ch == 3'h0) ? 7'h00 : 7'(7'h01 << (ch - 3'h1));
    endfunction

    // Levels stay up until the bench clears the station's channel
    assign req_lvl = chan_bit(silent_ch) | chan_bit(reply_ch);

    // The silent station always passes the grant on, so a replier wins
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            grant_q <= 1'b0;
            armed <= 1'b0;
            cnt <= 4'h0;
            fw_valid <= 1'b0;
            fw_data <= 36'h0;
        end else begin
            grant_q <= grant;
            fw_valid <= 1'b0;
            // Released data lines keep moving so no stale word looks valid
            fw_data <= ~fw_data;
            if (grant && !grant_q && reply_ch != 3'h0 && grant_chan == reply_ch) begin
                armed <= 1'b1;
                cnt <= delay;
            end else if (armed && cnt == 4'h0) begin
                armed <= 1'b0;
                fw_valid <= 1'b1;
                fw_data <= word;
            end else if (armed) begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* prio_if.sv */
// Channel vector and its highest-priority pick
`default_nettype none
interface prio_if;
    logic [6:0] vec;
    logic [2:0] idx;
    logic       any;
    logic [6:0] above;
    modport pick (input vec, output idx, output any, output above);
    modport user (output vec, input idx, input any, input above);
endinterface
`default_nettype wire

/* prio_pick.sv */
// Highest-priority channel picker; bit 0 is channel 1
`default_nettype none
module prio_pick (
    prio_if.pick p  // Vector in, pick out
);
    // Walk from lowest priority up so the highest set channel lands last
    always_comb begin
        p.idx   = 3'h0;
        p.any   = 1'b0;
        p.above = 7'h7f;
        for (int i = 6; i >= 0; i--) begin
            if (p.vec[i]) begin
                p.idx   = 3'(i);
                p.any   = 1'b1;
                p.above = 7'((8'h01 << i) - 8'h01);
            end
        end
    end
endmodule
`default_nettype wire

/* vectored_priority_interrupt_unit.sv */
// Priority interrupt unit: accept, grant, function word, start and dismiss
`include "vpiu_consts.svh"
`default_nettype none

//Contract
//RULE_01: Accept active-channel requests unless a channel waits or a start is underway.
//RULE_02: Defer accepted requests while holding the same or a higher channel.
//RULE_03: Grant the highest waiting channel that outranks the current program.
//RULE_04: Busy bus delays the grant; grant beats waiting IO, which stalls.
//RULE_05: A non-requesting peripheral passes the grant onward unchanged.
//RULE_06: A requesting peripheral ends the grant path and returns a function word.
//RULE_07: Start the interrupt at the first allowable stopping point after the word.
//RULE_08: On start, the program counter still points at the interrupted instruction.
//RULE_09: Channel N uses locations 40+2N and 41+2N; standard runs the first.
//RULE_10: Function code in bits 3-5; codes 0, 1 or no reply are standard.
//RULE_11: Code 2 dispatches to the address in bits 18-35.
//RULE_12: Code 3 adds signed bits 6-17 to the word at bits 18-35.
//RULE_13: Codes 4 and 5 do data-out or data-in at bits 18-35.
//RULE_14: Reserved codes 6 and 7 give a standard interrupt.
//RULE_15: Interrupt operations run in kernel mode.
//RULE_16: Interrupt operations never set overflow or trap flags.
//RULE_17: Page failure in an interrupt operation sets the IO page failure flag.
//RULE_18: Peripherals replying with a function word beat silent ones on a channel.
//RULE_19: Skip-class met dismisses with PC unchanged; otherwise run the second location.
//RULE_20: An unmet skip in the second location repeats until met.
//RULE_21: Jump-save class holds the channel and continues at the new PC.
//RULE_22: Other instructions dismiss and return to the prior mode.
//RULE_23: Channels 1 to 7, channel 1 highest; zero means no channel.
//RULE_24: A held channel blocks starts on itself and lower channels only.
//RULE_25: Peripheral requests stay asserted as levels until software clears them.
module vectored_priority_interrupt_unit
    import vpiu_pkg::*;
(
    input  wire logic        sys_clk,        // 20 MHz clock
    input  wire logic        rst_n,          // Async reset, active low
    input  wire logic [6:0]  req_lvl,        // Request levels, bit 0 is channel 1
    input  wire logic [6:0]  chan_on,        // Channel active
    input  wire logic        sys_on,         // Interrupt system on
    input  wire logic        io_bus_busy,    // In-out bus in use
    input  wire logic        io_instr_wait,  // An IO instruction waits for the bus
    input  wire logic        fw_valid,       // Function word strobe from chain
    input  wire logic [35:0] fw_data,        // Function word, bit 35 is LSB
    input  wire logic        stop_point,     // Processor at an allowable stop
    input  wire logic        instr_done,     // Interrupt instruction finished
    input  wire instr_cls_t  instr_cls,      // Its class
    input  wire logic        skip_met,       // Skip condition satisfied
    input  wire logic        is_monitor_uuo,        // Jump-save was the monitor call
    input  wire logic        page_fail,      // Page failure during operation
    input  wire logic        pf_clear,       // Software clears page failure flag
    input  wire logic [2:0]  proc_chan,      // Channel assigned to processor
    input  wire logic        sw_dismiss,     // Program dismisses held interrupt
    output logic             grant,          // Interrupt granted on bus
    output logic [2:0]       grant_chan,     // Granted channel number 1..7
    output logic             io_stall,       // Program stalled behind grant
    output logic             start_pulse,    // Interrupt starts, PC kept
    output var act_t         action,         // Interrupt function
    output logic [17:0]      exec_addr,      // Location or effective address
    output logic [35:0]      incr_value,     // Sign-extended increment
    output logic             kernel_mode,    // Operation in kernel mode
    output logic             flag_block,     // Inhibit overflow and trap flags
    output logic             dismiss,        // Interrupt dismissed
    output logic             resume_pc,      // Return to unchanged PC
    output logic             restore_mode,   // Return to prior mode
    output logic             mode_from_word, // Mode from monitor call PC word
    output logic             repeat_skip,    // Re-execute second location
    output logic [6:0]       held,           // Channels holding interrupts
    output logic             pf_flag         // IO page failure flag
);
    typedef struct packed {
        state_t      st;
        logic [6:0]  accepted;
        logic [6:0]  held;
        logic [2:0]  chan;
        logic [2:0]  gchan;
        act_t        act;
        logic [17:0] addr;
        logic [35:0] incr;
        logic [3:0]  cnt;
        logic        second;
        logic        grant;
        logic        io_stall;
        logic        kernel;
        logic        flag_block;
        logic        start_pulse;
        logic        dismiss;
        logic        resume_pc;
        logic        restore_mode;
        logic        mode_from_word;
        logic        repeat_skip;
        logic [17:0] exec_addr;
        logic        pf_flag;
    } unit_t;

    localparam logic [3:0] REPLY_LAST = 4'(`REPLY_CYC - 1);

    unit_t r_reg;
    unit_t r_next;
    prio_if hp ();
    prio_if wp ();
    logic        waiting;
    logic [6:0]  pf_req;
    logic [17:0] first_loc;
    logic [2:0]  fn;

    prio_pick u_held_pick (.p(hp));
    prio_pick u_wait_pick (.p(wp));

    assign hp.vec  = r_reg.held;
    assign wp.vec  = r_reg.accepted & hp.above;           // [RULE_02] [RULE_24]
    assign waiting = sys_on & wp.any;
    // The processor acts as a device on its assigned channel; zero means none
    assign pf_req  = (r_reg.pf_flag && proc_chan != 3'h0) ? 7'(8'h01 << (proc_chan - 3'h1)) : 7'h00;
    assign first_loc = `VEC_BASE + {14'h0, 3'(r_reg.chan + 3'h1), 1'b0}; // [RULE_09] [RULE_23]
    assign fn = fw_data[`FN_CODE_HI:`FN_CODE_LO];

    always_comb begin
        r_next = r_reg;
        r_next.start_pulse    = 1'b0;
        r_next.dismiss        = 1'b0;
        r_next.resume_pc      = 1'b0;
        r_next.restore_mode   = 1'b0;
        r_next.mode_from_word = 1'b0;
        r_next.repeat_skip    = 1'b0;
        // Levels stay up until software clears them, so a refused one returns
        if (!waiting && r_reg.st == ST_IDLE) begin
            r_next.accepted = r_reg.accepted | ((req_lvl | pf_req) & chan_on); // [RULE_01] [RULE_25]
        end
        if (sw_dismiss && hp.any) begin
            r_next.held[hp.idx] = 1'b0;
        end
        r_next.pf_flag = r_reg.pf_flag & ~pf_clear;
        case (r_reg.st)
            ST_IDLE: begin
                if (waiting) begin
                    r_next.chan = wp.idx;                   // [RULE_03]
                    r_next.gchan = 3'(wp.idx + 3'h1);       // [RULE_23]
                    r_next.st   = ST_BUSWAIT;
                end
            end
            ST_BUSWAIT: begin
                if (!io_bus_busy) begin                     // [RULE_04]
                    r_next.grant = 1'b1;
                    r_next.cnt   = 4'h0;
                    r_next.st    = ST_GRANT;
                end
            end
            ST_GRANT: begin
                // A replying peripheral outranks silent ones on the same channel
                if (fw_valid) begin                         // [RULE_06] [RULE_18]
                    r_next.grant = 1'b0;
                    r_next.st    = ST_STARTPEND;
                    r_next.addr  = fw_data[`FN_ADDR_HI:`FN_ADDR_LO];
                    r_next.incr  = {{24{fw_data[`FN_INCR_SIGN]}}, fw_data[`FN_INCR_HI:`FN_INCR_LO]}; // [RULE_12]
                    case (fn)
                        `FN_DISPATCH:  r_next.act = ACT_DISPATCH; // [RULE_11]
                        `FN_INCREMENT: r_next.act = ACT_INCR;
                        `FN_DATA_OUT:  r_next.act = ACT_DOUT;     // [RULE_13]
                        `FN_DATA_IN:   r_next.act = ACT_DIN;
                        default:       r_next.act = ACT_STD;      // [RULE_10] [RULE_14]
                    endcase
                end else if (r_reg.cnt == REPLY_LAST) begin   // [RULE_10]
                    r_next.grant = 1'b0;
                    r_next.act   = ACT_STD;
                    r_next.st    = ST_STARTPEND;
                end else begin
                    r_next.cnt = r_reg.cnt + 4'h1;
                end
            end
            ST_STARTPEND: begin
                if (stop_point) begin                       // [RULE_07]
                    r_next.start_pulse = 1'b1;              // [RULE_08]
                    r_next.kernel      = 1'b1;              // [RULE_15]
                    r_next.flag_block  = 1'b1;              // [RULE_16]
                    r_next.second      = 1'b0;
                    r_next.accepted[r_reg.chan] = 1'b0;
                    r_next.exec_addr   = (r_reg.act == ACT_STD) ? first_loc : r_reg.addr;
                    r_next.st          = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (instr_done) begin
                    r_next.st         = ST_IDLE;
                    r_next.kernel     = 1'b0;
                    r_next.flag_block = 1'b0;
                    case (instr_cls)
                        CLS_SKIP: begin
                            if (skip_met) begin             // [RULE_19]
                                r_next.dismiss   = 1'b1;
                                r_next.resume_pc = 1'b1;
                            end else begin
                                r_next.st         = ST_EXEC;
                                r_next.kernel     = 1'b1;
                                r_next.flag_block = 1'b1;
                                if (r_reg.second) begin
                                    r_next.repeat_skip = 1'b1; // [RULE_20]
                                end else begin
                                    r_next.second    = 1'b1;
                                    r_next.exec_addr = r_reg.exec_addr + 18'h1;
                                end
                            end
                        end
                        CLS_JSAVE: begin
                            r_next.held[r_reg.chan] = 1'b1; // [RULE_21]
                            r_next.mode_from_word   = is_monitor_uuo;
                        end
                        default: begin
                            r_next.dismiss      = 1'b1;     // [RULE_22]
                            r_next.restore_mode = 1'b1;
                        end
                    endcase
                end
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase
        // Trapping would lose the operation, so the failure becomes a request
        if (r_reg.st == ST_EXEC && page_fail) begin
            r_next.pf_flag = 1'b1;                          // [RULE_17]
        end
        r_next.io_stall = io_instr_wait && (r_next.st == ST_BUSWAIT || r_next.st == ST_GRANT); // [RULE_04]
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_reg <= '0;
        end else begin
            r_reg <= r_next;
        end
    end

    assign grant          = r_reg.grant;
    assign grant_chan     = r_reg.gchan;
    assign io_stall       = r_reg.io_stall;
    assign start_pulse    = r_reg.start_pulse;
    assign action         = r_reg.act;
    assign exec_addr      = r_reg.exec_addr;
    assign incr_value     = r_reg.incr;
    assign kernel_mode    = r_reg.kernel;
    assign flag_block     = r_reg.flag_block;
    assign dismiss        = r_reg.dismiss;
    assign resume_pc      = r_reg.resume_pc;
    assign restore_mode   = r_reg.restore_mode;
    assign mode_from_word = r_reg.mode_from_word;
    assign repeat_skip    = r_reg.repeat_skip;
    assign held           = r_reg.held;
    assign pf_flag        = r_reg.pf_flag;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence s_silent_grant;
        r_reg.st == ST_GRANT && r_reg.grant && r_reg.cnt == REPLY_LAST && !fw_valid;
    endsequence
    sequence s_skip_unmet;
        r_reg.st == ST_EXEC && instr_done && instr_cls == CLS_SKIP && !skip_met;
    endsequence

    property p_no_accept_busy;
        (r_reg.st != ST_IDLE) |=> ((r_reg.accepted & ~$past(r_reg.accepted)) == 7'h00);
    endproperty
    a_no_accept_busy: assert property (p_no_accept_busy) else $error("request accepted during start"); // [RULE_01]
    property p_defer;
        (r_reg.st == ST_IDLE && !waiting) |=> (r_reg.st == ST_IDLE);
    endproperty
    a_defer: assert property (p_defer) else $error("start without eligible waiting channel"); // [RULE_02]
    property p_pick;
        (r_reg.st == ST_IDLE && waiting) |=> (r_reg.chan == $past(wp.idx) && r_reg.st == ST_BUSWAIT);
    endproperty
    a_pick: assert property (p_pick) else $error("wrong channel granted"); // [RULE_03]
    property p_bus_busy;
        (r_reg.st == ST_BUSWAIT && io_bus_busy && io_instr_wait) |=> (!r_reg.grant && r_reg.io_stall);
    endproperty
    a_bus_busy: assert property (p_bus_busy) else $error("grant on busy bus or program not stalled"); // [RULE_04]
    property p_no_reply;
        s_silent_grant |=> (r_reg.st == ST_STARTPEND && r_reg.act == ACT_STD && !r_reg.grant);
    endproperty
    a_no_reply: assert property (p_no_reply) else $error("silent chain did not give standard"); // [RULE_10]
    property p_dispatch;
        (r_reg.st == ST_GRANT && fw_valid && fn == `FN_DISPATCH)
            |=> (r_reg.act == ACT_DISPATCH && r_reg.addr == $past(fw_data[17:0]));
    endproperty
    a_dispatch: assert property (p_dispatch) else $error("dispatch not decoded"); // [RULE_11]
    property p_start;
        (r_reg.st == ST_STARTPEND && stop_point) |=> (r_reg.start_pulse && r_reg.kernel && r_reg.flag_block);
    endproperty
    a_start: assert property (p_start) else $error("start missing at stop point"); // [RULE_07]
    property p_std_vec;
        (r_reg.start_pulse && r_reg.act == ACT_STD)
            |-> (r_reg.exec_addr == 18'h20 + 18'(2 * (r_reg.chan + 1)));
    endproperty
    a_std_vec: assert property (p_std_vec) else $error("standard vector wrong"); // [RULE_09]
    property p_second;
        (s_skip_unmet ##0 !r_reg.second) |=> (r_reg.second && r_reg.exec_addr == $past(r_reg.exec_addr) + 18'h1);
    endproperty
    a_second: assert property (p_second) else $error("second location not taken"); // [RULE_19]
    property p_hang;
        (s_skip_unmet ##0 r_reg.second) |=> (r_reg.repeat_skip && r_reg.st == ST_EXEC && !r_reg.dismiss);
    endproperty
    a_hang: assert property (p_hang) else $error("unmet second skip did not repeat"); // [RULE_20]
    property p_jsave;
        (r_reg.st == ST_EXEC && instr_done && instr_cls == CLS_JSAVE)
            |=> (r_reg.held[$past(r_reg.chan)] && !r_reg.dismiss);
    endproperty
    a_jsave: assert property (p_jsave) else $error("jump-save did not hold channel"); // [RULE_21]
    property p_pf;
        (r_reg.st == ST_EXEC && page_fail) |=> r_reg.pf_flag;
    endproperty
    a_pf: assert property (p_pf) else $error("page failure flag not set"); // [RULE_17]
endmodule
`default_nettype wire

/* vectored_priority_interrupt_unit_tb.sv */
// Self-checking bench for the priority interrupt unit
`include "vpiu_consts.svh"
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("unexpected %0t %h %h", $time, g, e); end end
module vectored_priority_interrupt_unit_tb import vpiu_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic        sys_clk, rst_n, sys_on, io_bus_busy, io_instr_wait, fw_valid, stop_point, instr_done;
    logic        skip_met, is_monitor_uuo, page_fail, pf_clear, sw_dismiss, grant, io_stall, start_pulse;
    logic        kernel_mode, flag_block, dismiss, resume_pc, restore_mode, mode_from_word, repeat_skip, pf_flag;
    logic [6:0]  req_lvl, chan_on, held;
    logic [2:0]  proc_chan, grant_chan, silent_ch, reply_ch;
    logic [35:0] fw_data, incr_value, word;
    logic [17:0] exec_addr;
    logic [3:0]  delay;
    instr_cls_t  instr_cls;
    act_t        action;
    int          n_fail, n_tests;

    vectored_priority_interrupt_unit dut (.sys_clk(sys_clk), .rst_n(rst_n), .req_lvl(req_lvl), .chan_on(chan_on),
        .sys_on(sys_on), .io_bus_busy(io_bus_busy), .io_instr_wait(io_instr_wait), .fw_valid(fw_valid),
        .fw_data(fw_data), .stop_point(stop_point), .instr_done(instr_done), .instr_cls(instr_cls),
        .skip_met(skip_met), .is_monitor_uuo(is_monitor_uuo), .page_fail(page_fail), .pf_clear(pf_clear), .proc_chan(proc_chan),
        .sw_dismiss(sw_dismiss), .grant(grant), .grant_chan(grant_chan), .io_stall(io_stall),
        .start_pulse(start_pulse), .action(action), .exec_addr(exec_addr), .incr_value(incr_value),
        .kernel_mode(kernel_mode), .flag_block(flag_block), .dismiss(dismiss), .resume_pc(resume_pc),
        .restore_mode(restore_mode), .mode_from_word(mode_from_word), .repeat_skip(repeat_skip), .held(held),
        .pf_flag(pf_flag));
    periph_chain chain (.sys_clk(sys_clk), .rst_n(rst_n), .grant(grant), .grant_chan(grant_chan),
        .silent_ch(silent_ch), .reply_ch(reply_ch), .word(word), .delay(delay), .req_lvl(req_lvl),
        .fw_valid(fw_valid), .fw_data(fw_data));

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    function automatic logic [35:0] fword(input logic [2:0] code, input logic [11:0] inc, input logic [17:0] adr);
        return {3'h0, code, inc, adr};
    endfunction

    function automatic logic [17:0] std_loc(input logic [2:0] ch);
        return `VEC_BASE + {14'h0, ch, 1'b0};
    endfunction

    task automatic start_irq(input logic [2:0] ch, input act_t act, input logic [17:0] adr);
        int i;
        for (i = 0; i < 40 && grant !== 1'b1; i++) cyc(1);
        `CHK(grant, 1'b1)
        `CHK(grant_chan, ch)
        for (i = 0; i < 40 && grant !== 1'b0; i++) cyc(1);
        `CHK(action, act)
        cyc(2);
        `CHK(start_pulse, 1'b0)
        stop_point = 1'b1;
        cyc(1);
        stop_point = 1'b0;
        `CHK({start_pulse, kernel_mode, flag_block}, 3'h7)
        `CHK(exec_addr, adr)
        // The handler clears the device so the level drops after the start
        if (reply_ch == ch) reply_ch = 3'h0;
        if (silent_ch == ch) silent_ch = 3'h0;
    endtask

    // Pulse order: dismiss, resume_pc, restore_mode, mode_from_word, repeat_skip
    task automatic complete(input instr_cls_t cls, input logic met, input logic monitor_uuo, input logic [4:0] pulses,
                            input logic [17:0] adr, input logic stay);
        instr_done = 1'b1;
        instr_cls = cls;
        skip_met = met;
        is_monitor_uuo = monitor_uuo;
        cyc(1);
        instr_done = 1'b0;
        `CHK({dismiss, resume_pc, restore_mode, mode_from_word, repeat_skip}, pulses)
        `CHK(kernel_mode, stay)
        if (stay) `CHK(exec_addr, adr)
        cyc(1);
    endtask

    task automatic t_std();
        int k;
        logic [2:0] ch;
        for (k = 0; k < 5; k++) begin
            ch = 3'(k + 3);
            word = fword(3'(k < 2 ? k : k + 4), 12'h000, 18'h3ffff);
            if (k < 4) reply_ch = ch;
            else silent_ch = ch;
            start_irq(ch, ACT_STD, std_loc(ch));
            complete(CLS_OTHER, 1'b0, 1'b0, 5'b10100, 18'h0, 1'b0);
        end
        $display("test standard done");
    endtask

    task automatic t_dispatch();
        delay = 4'h4;
        word = fword(`FN_DISPATCH, 12'h000, 18'h1234c);
        reply_ch = 3'h3;
        silent_ch = 3'h3;
        start_irq(3'h3, ACT_DISPATCH, 18'h1234c);
        complete(CLS_SKIP, 1'b0, 1'b0, 5'b00000, 18'h1234d, 1'b1);
        complete(CLS_SKIP, 1'b0, 1'b0, 5'b00001, 18'h1234d, 1'b1);
        complete(CLS_SKIP, 1'b1, 1'b0, 5'b11000, 18'h0, 1'b0);
        delay = 4'h0;
        $display("test dispatch done");
    endtask

    task automatic t_data();
        int k;
        word = fword(`FN_INCREMENT, 12'h801, 18'h00456);
        reply_ch = 3'h2;
        start_irq(3'h2, ACT_INCR, 18'h00456);
        `CHK(incr_value, 36'hffffff801)
        complete(CLS_OTHER, 1'b0, 1'b0, 5'b10100, 18'h0, 1'b0);
        for (k = 0; k < 2; k++) begin
            word = fword(3'(`FN_DATA_OUT + k), 12'h000, 18'h2a5a5);
            reply_ch = 3'h2;
            start_irq(3'h2, k == 0 ? ACT_DOUT : ACT_DIN, 18'h2a5a5);
            complete(CLS_OTHER, 1'b0, 1'b0, 5'b10100, 18'h0, 1'b0);
        end
        $display("test data done");
    endtask

    task automatic t_hold();
        word = fword(`FN_STANDARD, 12'h000, 18'h0);
        reply_ch = 3'h2;
        silent_ch = 3'h5;
        start_irq(3'h2, ACT_STD, std_loc(3'h2));
        complete(CLS_JSAVE, 1'b0, 1'b1, 5'b00010, 18'h0, 1'b0);
        `CHK(held, 7'h02)
        cyc(20);
        `CHK(grant, 1'b0)
        sw_dismiss = 1'b1;
        cyc(1);
        sw_dismiss = 1'b0;
        `CHK(held, 7'h00)
        start_irq(3'h5, ACT_STD, std_loc(3'h5));
        complete(CLS_OTHER, 1'b0, 1'b0, 5'b10100, 18'h0, 1'b0);
        $display("test hold done");
    endtask

    task automatic t_gate();
        word = fword(`FN_STANDARD, 12'h000, 18'h0);
        chan_on = 7'h77;
        reply_ch = 3'h4;
        cyc(10);
        `CHK(grant, 1'b0)
        sys_on = 1'b0;
        chan_on = 7'h7f;
        cyc(10);
        `CHK(grant, 1'b0)
        io_bus_busy = 1'b1;
        io_instr_wait = 1'b1;
        sys_on = 1'b1;
        cyc(6);
        `CHK({grant, io_stall}, 2'b01)
        io_bus_busy = 1'b0;
        cyc(2);
        `CHK(grant, 1'b1)
        start_irq(3'h4, ACT_STD, std_loc(3'h4));
        io_instr_wait = 1'b0;
        complete(CLS_OTHER, 1'b0, 1'b0, 5'b10100, 18'h0, 1'b0);
        $display("test gating done");
    endtask

    task automatic t_pf();
        proc_chan = 3'h6;
        word = fword(`FN_STANDARD, 12'h000, 18'h0);
        reply_ch = 3'h1;
        start_irq(3'h1, ACT_STD, std_loc(3'h1));
        page_fail = 1'b1;
        cyc(1);
        page_fail = 1'b0;
        `CHK(pf_flag, 1'b1)
        complete(CLS_OTHER, 1'b0, 1'b0, 5'b10100, 18'h0, 1'b0);
        start_irq(3'h6, ACT_STD, std_loc(3'h6));
        pf_clear = 1'b1;
        cyc(1);
        pf_clear = 1'b0;
        `CHK(pf_flag, 1'b0)
        complete(CLS_OTHER, 1'b0, 1'b0, 5'b10100, 18'h0, 1'b0);
        $display("test page failure done");
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    initial begin
        n_fail = 0;
        n_tests = 0;
        {rst_n, io_bus_busy, io_instr_wait, stop_point, instr_done, skip_met, is_monitor_uuo} = 7'h00;
        {page_fail, pf_clear, sw_dismiss, proc_chan, silent_ch, reply_ch, delay} = 16'h0000;
        sys_on = 1'b1;
        chan_on = 7'h7f;
        instr_cls = CLS_OTHER;
        word = 36'h0;
        cyc(10);
        rst_n = 1'b1;
        cyc(1);
        `CHK({grant, start_pulse, kernel_mode, dismiss, pf_flag, held}, 12'h000)
        `CHK(action, ACT_STD)
        $display("test reset done");
        t_std();
        t_dispatch();
        t_data();
        t_hold();
        t_gate();
        t_pf();
        test_done();
    end

    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        n_fail++;
        test_done();
    end
endmodule
`default_nettype wire

/* vpiu_consts.svh */
// Constants for the vectored priority interrupt unit
`ifndef VPIU_CONSTS_SVH
`define VPIU_CONSTS_SVH

`define CHANNELS        7
`define CLK_PERIOD_NS   50
`define REPLY_WAIT_NS   500
`define REPLY_CYC       ((`REPLY_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FN_CODE_HI      32
`define FN_CODE_LO      30
`define FN_INCR_SIGN    29
`define FN_INCR_HI      29
`define FN_INCR_LO      18
`define FN_ADDR_HI      17
`define FN_ADDR_LO      0
`define VEC_BASE        18'h20
`define FN_PROC_WAIT    3'h0
`define FN_STANDARD     3'h1
`define FN_DISPATCH     3'h2
`define FN_INCREMENT    3'h3
`define FN_DATA_OUT     3'h4
`define FN_DATA_IN      3'h5

`endif

/* vpiu_pkg.sv */
// Types shared by the interrupt unit modules
`default_nettype none
package vpiu_pkg;
    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_BUSWAIT   = 3'b001,
        ST_GRANT     = 3'b010,
        ST_STARTPEND = 3'b011,
        ST_EXEC      = 3'b100
    } state_t;
    typedef enum logic [2:0] {
        ACT_STD      = 3'b000,
        ACT_DISPATCH = 3'b001,
        ACT_INCR     = 3'b010,
        ACT_DOUT     = 3'b011,
        ACT_DIN      = 3'b100
    } act_t;
    typedef enum logic [1:0] {
        CLS_SKIP  = 2'b00,
        CLS_JSAVE = 2'b01,
        CLS_OTHER = 2'b10
    } instr_cls_t;
endpackage
`default_nettype wire
